// File: src/debug_port_pkg.sv
/*
  Shared constants for the debug port: register map, scan
  instructions, scan field layout and tap states.
  Assumes a 32-bit Wishbone slave and a 10-byte flash ID.
*/
package debug_port_pkg;
  localparam logic [7:0] ADR_MODE  = 8'h00;
  localparam logic [7:0] ADR_PROT  = 8'h04;
  localparam logic [7:0] ADR_BITOP = 8'h08;
  localparam logic [7:0] ADR_STAT  = 8'h0c;
  localparam logic [7:0] PROT_KEY  = 8'ha5;
  localparam logic [1:0] MODE_RST  = 2'h1;
  localparam int MODE_EN = 0;
  localparam int MODE_PD = 1;
  localparam int AW = 16;
  localparam int DW = 8;
  localparam int PCW = 24;
  localparam int NBP_HW = 2;
  localparam int NBP = 6;
  localparam int DR_W = 80;
  localparam int ID_EN = 79;
  localparam logic [3:0] IR_BYPASS = 4'hf;
  localparam logic [3:0] IR_IDENT  = 4'h1;
  localparam logic [3:0] IR_MEM    = 4'h2;
  localparam logic [3:0] IR_CTRL   = 4'h3;
  localparam logic [3:0] IR_BP     = 4'h4;
  localparam logic [3:0] IR_STAT   = 4'h5;
  localparam logic [3:0] IR_CAP    = 4'h1;
  localparam logic [6:0] LEN_ID = 7'h50;
  localparam logic [6:0] LEN_MEM = 7'h19;
  localparam logic [6:0] LEN_CTRL = 7'h06;
  localparam logic [6:0] LEN_BP = 7'h1c;
  localparam logic [6:0] LEN_STAT = 7'h08;
  localparam logic [6:0] LEN_BYP = 7'h01;
  localparam int MEM_WE = 0;
  localparam int MEM_ADR = 1;
  localparam int MEM_DAT = 17;
  localparam int CT_BRK = 0;
  localparam int CT_RES = 1;
  localparam int CT_MSK = 2;
  localparam int BP_SLOT = 0;
  localparam int BP_EN = 3;
  localparam int BP_ADR = 4;
  localparam int SYNC_W = 9;
  localparam int S_DEBUG_RESET_N = 0;
  localparam int S_DCK = 1;
  localparam int S_DMS = 2;
  localparam int S_DDI = 3;
  localparam int S_P5 = 4;
  localparam int S_RST = 5;
  localparam int S_NMI = 6;
  localparam int S_HLD = 7;
  localparam int S_WAIT = 8;
  typedef enum logic [3:0] {
    TLR = 4'h0, RTI = 4'h1, SELDR = 4'h3, CAPDR = 4'h2,
    SHDR = 4'h6, EX1DR = 4'h7, PADR = 4'h5, EX2DR = 4'h4,
    UPDR = 4'hc, SELIR = 4'hd, CAPIR = 4'hf, SHIR = 4'he,
    EX1IR = 4'ha, PAIR = 4'hb, EX2IR = 4'h9, UPIR = 4'h8
  } tap_state_t;
endpackage

// File: src/pin_sync.sv
/*
  Three-stage pin synchroniser with agreement filter.
  Assumes inputs are asynchronous to i_mclk.
*/
`timescale 1ns/10ps
module pin_sync #(parameter int W = 1) (
  input  logic         i_mclk,
  input  logic         i_rstn,
  input  logic [W-1:0] i_async,
  output logic [W-1:0] o_level
);
  logic [W-1:0] s1_q, s2_q, s3_q, lvl_q;
  always_ff @(posedge i_mclk)
  begin
    if (!i_rstn)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end
    else
    begin
      s1_q <= i_async;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  // A change counts only once stages two and three agree
  for (genvar g = 0; g < W; g++)
  begin : g_flt
    always_ff @(posedge i_mclk)
    begin
      if (!i_rstn)
        lvl_q[g] <= 1'b0;
      else if (s2_q[g] == s3_q[g])
        lvl_q[g] <= s3_q[g];
    end
  end
  assign o_level = lvl_q;
endmodule

// File: src/tap_ctrl.sv
/*
  Serial transfer state machine of the debug port.
  Assumes i_adv is a one-cycle strobe per debug clock rise.
*/
`timescale 1ns/10ps
module tap_ctrl (
  input  logic                        i_mclk,
  input  logic                        i_arst_n,
  input  logic                        i_adv,
  input  logic                        i_tms,
  output debug_port_pkg::tap_state_t  o_state
);
  debug_port_pkg::tap_state_t st_q, st_d;
  always_comb
  begin
    case (st_q)
      debug_port_pkg::TLR:   st_d = i_tms ? debug_port_pkg::TLR
                                          : debug_port_pkg::RTI;
      debug_port_pkg::RTI:   st_d = i_tms ? debug_port_pkg::SELDR
                                          : debug_port_pkg::RTI;
      debug_port_pkg::SELDR: st_d = i_tms ? debug_port_pkg::SELIR
                                          : debug_port_pkg::CAPDR;
      debug_port_pkg::CAPDR: st_d = i_tms ? debug_port_pkg::EX1DR
                                          : debug_port_pkg::SHDR;
      debug_port_pkg::SHDR:  st_d = i_tms ? debug_port_pkg::EX1DR
                                          : debug_port_pkg::SHDR;
      debug_port_pkg::EX1DR: st_d = i_tms ? debug_port_pkg::UPDR
                                          : debug_port_pkg::PADR;
      debug_port_pkg::PADR:  st_d = i_tms ? debug_port_pkg::EX2DR
                                          : debug_port_pkg::PADR;
      debug_port_pkg::EX2DR: st_d = i_tms ? debug_port_pkg::UPDR
                                          : debug_port_pkg::SHDR;
      debug_port_pkg::SELIR: st_d = i_tms ? debug_port_pkg::TLR
                                          : debug_port_pkg::CAPIR;
      debug_port_pkg::CAPIR: st_d = i_tms ? debug_port_pkg::EX1IR
                                          : debug_port_pkg::SHIR;
      debug_port_pkg::SHIR:  st_d = i_tms ? debug_port_pkg::EX1IR
                                          : debug_port_pkg::SHIR;
      debug_port_pkg::EX1IR: st_d = i_tms ? debug_port_pkg::UPIR
                                          : debug_port_pkg::PAIR;
      debug_port_pkg::PAIR:  st_d = i_tms ? debug_port_pkg::EX2IR
                                          : debug_port_pkg::PAIR;
      debug_port_pkg::EX2IR: st_d = i_tms ? debug_port_pkg::UPIR
                                          : debug_port_pkg::SHIR;
      debug_port_pkg::UPDR,
      debug_port_pkg::UPIR:  st_d = i_tms ? debug_port_pkg::SELDR
                                          : debug_port_pkg::RTI;
      default:               st_d = debug_port_pkg::TLR;
    endcase
  end
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      st_q <= debug_port_pkg::TLR;
    else if (i_adv)
      st_q <= st_d;
  end
  assign o_state = st_q;
endmodule

// File: src/debug_port_top.sv
/*
  On-chip debug unit: serial debug port, mode register on
  Wishbone, ID unlock, breakpoints, masks, memory monitor.
  Assumes i_mem_* is a same-clock memory port and the debug
  pins are asynchronous to i_mclk.
*/
// Our own choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/10ps
// Function
// RULE1: Debug reset low clears debug logic asynchronously
// RULE2: Debug reset rising also resets the CPU
// RULE3: Emulator drives debug clock at 20 MHz; the probe model drives a 160 ns period (6.25 MHz)
// RULE4: Mode select and data sampled on clock rise
// RULE5: Data out changes only on clock fall
// RULE6: Transfer state follows sampled mode select
// RULE7: Unpowered target sees emulator outputs floating
// RULE8: Emulator drives flash mode pin for downloads
// RULE9: Mode writes need unlock sequence, pin five low
// RULE10: Mode register byte and bit access
// RULE11: Mode register selects pins and pull-down
// RULE12: Debug valid only when enabled and reset high
// RULE13: Unused debug reset held low until disabled
// RULE14: System reset restores mode register defaults
// RULE15: Ten-byte ID match unlocks debug access
// RULE16: ID enable bit zero refuses debugging
// RULE17: Debug mode drives data out high
// RULE18: Pin reset masked while stopped at break
// RULE19: Masks for reset, NMI, hold, wait
// RULE20: Two hardware and four software breakpoints
// RULE21: Software breakpoints sleep after resets
// RULE22: Memory read and RAM write while running
// RULE23: Test-access-port style one-bit serial shifting
module debug_port_top (
  input  logic        i_mclk,
  input  logic        i_rstn,
  input  logic        i_wb_cyc,
  input  logic        i_wb_stb,
  input  logic        i_wb_we,
  input  logic [7:0]  i_wb_adr,
  input  logic [31:0] i_wb_dat,
  input  logic [3:0]  i_wb_sel,
  output logic [31:0] o_wb_dat,
  output logic        o_wb_ack,
  input  logic        i_debug_reset_n,
  input  logic        i_debug_clock,
  input  logic        i_debug_mode_select,
  input  logic        i_debug_data_in,
  output logic        o_debug_data_out,
  output logic        o_debug_data_out_en_n,
  input  logic        i_shared_pin_five,
  input  logic        i_reset_pin_n,
  input  logic        i_nmi,
  input  logic        i_bus_hold_request,
  input  logic        i_wait_req,
  input  logic        i_wdt2_reset,
  input  logic [23:0] i_cpu_pc,
  input  logic        i_cpu_fetch,
  input  logic [79:0] i_flash_id,
  output logic        o_cpu_reset_n,
  output logic        o_port_reset_n,
  output logic        o_cpu_break,
  output logic        o_nmi,
  output logic        o_bus_hold_request,
  output logic        o_wait,
  output logic        o_debug_pins_sel,
  output logic        o_pulldown_off,
  output logic        o_mem_req,
  output logic        o_mem_we,
  output logic [15:0] o_mem_addr,
  output logic [7:0]  o_mem_wdata,
  input  logic        i_mem_ack,
  input  logic [7:0]  i_mem_rdata
);
  localparam int SW = debug_port_pkg::SYNC_W;
  localparam int NBP = debug_port_pkg::NBP;
  localparam int PCW = debug_port_pkg::PCW;
  localparam int DRW = debug_port_pkg::DR_W;

  logic [SW-1:0]  pin_raw, lvl;
  logic           dck_q, debug_reset_n_q, ddo_q, ddo_en_n_q;
  logic           cpu_rst_n_q, port_rst_n_q;
  logic           nmi_q, hold_q, wait_q, armed_q, ack_q;
  logic [1:0]     mode_q;
  logic [31:0]    dat_q;
  logic [3:0]     ir_q, irs_q, mask_q;
  logic [DRW-1:0] sh_q, sh_d, cap_val;
  logic           sec_ok_q, break_q, sw_active_q;
  logic           mem_req_q, mem_we_q;
  logic [15:0]    mem_adr_q;
  logic [7:0]     mem_wdat_q, mem_rdat_q;
  logic           bp_en_q [NBP];
  logic [PCW-1:0] bp_adr_q [NBP];
  logic [NBP-1:0] hit;
  debug_port_pkg::tap_state_t st;

  assign pin_raw = {i_wait_req, i_bus_hold_request, i_nmi,
                    i_reset_pin_n, i_shared_pin_five,
                    i_debug_data_in, i_debug_mode_select,
                    i_debug_clock, i_debug_reset_n};

  pin_sync #(.W(SW)) u_sync (
    .i_mclk  (i_mclk),
    .i_rstn  (i_rstn),
    .i_async (pin_raw),
    .o_level (lvl)
  );

  wire debug_clock  = lvl[debug_port_pkg::S_DCK];
  wire debug_reset_n = lvl[debug_port_pkg::S_DEBUG_RESET_N];
  wire debug_mode_select  = lvl[debug_port_pkg::S_DMS];
  wire debug_data_in  = lvl[debug_port_pkg::S_DDI];
  wire rst_pin = ~lvl[debug_port_pkg::S_RST];
  wire dck_rise = debug_clock & ~dck_q;
  wire dck_fall = ~debug_clock & dck_q;
  wire debug_reset_n_rise = debug_reset_n & ~debug_reset_n_q;
  // RULE12: enable bit and reset
  wire dbg_valid = mode_q[debug_port_pkg::MODE_EN] & debug_reset_n;
  // RULE4: sample on rise
  wire adv = dck_rise & dbg_valid;

  // RULE6: state follows mode select
  tap_ctrl u_tap (
    .i_mclk   (i_mclk),
    .i_arst_n (i_debug_reset_n),
    .i_adv    (adv),
    .i_tms    (debug_mode_select),
    .o_state  (st)
  );

  wire sh_dr = st == debug_port_pkg::SHDR;
  wire sh_ir = st == debug_port_pkg::SHIR;
  wire upd = adv & (st == debug_port_pkg::UPDR);
  wire upd_ok = upd & sec_ok_q;
  wire is_id = ir_q == debug_port_pkg::IR_IDENT;
  wire is_mem = ir_q == debug_port_pkg::IR_MEM;
  wire is_ctl = ir_q == debug_port_pkg::IR_CTRL;
  wire is_bp = ir_q == debug_port_pkg::IR_BP;
  wire is_st = ir_q == debug_port_pkg::IR_STAT;
  wire mem_upd = upd_ok & is_mem;
  wire ctl_upd = upd_ok & is_ctl;
  wire bp_upd = upd_ok & is_bp;
  wire force_brk = ctl_upd & sh_q[debug_port_pkg::CT_BRK];
  wire resume = ctl_upd & sh_q[debug_port_pkg::CT_RES];
  wire [2:0] bp_slot = sh_q[debug_port_pkg::BP_SLOT +: 3];
  wire hw_hit = |hit[debug_port_pkg::NBP_HW-1:0];
  wire any_hit = |hit;
  // RULE15: whole ID compared
  wire id_match = sh_q == i_flash_id;
  wire [7:0] stat = {3'h0, mem_req_q, sw_active_q, sec_ok_q,
                     break_q, dbg_valid};
  wire [6:0] dr_len = is_id  ? debug_port_pkg::LEN_ID :
                      is_mem ? debug_port_pkg::LEN_MEM :
                      is_ctl ? debug_port_pkg::LEN_CTRL :
                      is_bp  ? debug_port_pkg::LEN_BP :
                      is_st  ? debug_port_pkg::LEN_STAT :
                               debug_port_pkg::LEN_BYP;
  assign cap_val = is_mem ? {55'h0, mem_rdat_q, 17'h0} :
                   is_st  ? {72'h0, stat} : {DRW{1'b0}};
  wire tdo_bit = sh_ir ? irs_q[0] : sh_q[0];
  // RULE19: masks act only in debug mode
  wire [3:0] m_eff = mask_q & {4{dbg_valid}};
  // RULE18: pin reset ignored at a break
  wire pin_rst_eff = rst_pin & ~(break_q & dbg_valid) & ~m_eff[0];

  // RULE23: one bit per clock, length per instruction
  always_comb
  begin
    sh_d = sh_q;
    if (adv && st == debug_port_pkg::CAPDR)
      sh_d = cap_val;
    else if (adv && sh_dr)
    begin
      sh_d = sh_q >> 1;
      sh_d[dr_len - 7'h01] = debug_data_in;
    end
  end

  // RULE1: debug side cleared by the debug reset pin
  always_ff @(posedge i_mclk or negedge i_debug_reset_n)
  begin
    if (!i_debug_reset_n)
    begin
      ir_q <= debug_port_pkg::IR_BYPASS;
      irs_q <= debug_port_pkg::IR_CAP;
      sh_q <= '0;
      sec_ok_q <= 1'b0;
      mask_q <= 4'h0;
      break_q <= 1'b0;
      sw_active_q <= 1'b1;
      mem_req_q <= 1'b0;
      mem_we_q <= 1'b0;
      mem_adr_q <= 16'h0;
      mem_wdat_q <= 8'h0;
      mem_rdat_q <= 8'h0;
    end
    else
    begin
      sh_q <= sh_d;
      if (adv && st == debug_port_pkg::CAPIR)
        irs_q <= debug_port_pkg::IR_CAP;
      else if (adv && sh_ir)
        irs_q <= {debug_data_in, irs_q[3:1]};
      if (st == debug_port_pkg::TLR)
        ir_q <= debug_port_pkg::IR_BYPASS;
      else if (adv && st == debug_port_pkg::UPIR)
        ir_q <= irs_q;
      // RULE16: enable flag must be set too
      if (upd && is_id)
        sec_ok_q <= id_match & i_flash_id[debug_port_pkg::ID_EN];
      if (ctl_upd)
        mask_q <= sh_q[debug_port_pkg::CT_MSK +: 4];
      if (force_brk || any_hit)
        break_q <= 1'b1;
      else if (resume)
        break_q <= 1'b0;
      // RULE21: set wins over the resets
      if (force_brk || hw_hit)
        sw_active_q <= 1'b1;
      else if (i_wdt2_reset || pin_rst_eff)
        sw_active_q <= 1'b0;
      // RULE22: no break needed for memory access
      if (mem_upd && !mem_req_q)
      begin
        mem_req_q <= 1'b1;
        mem_we_q <= sh_q[debug_port_pkg::MEM_WE];
        mem_adr_q <= sh_q[debug_port_pkg::MEM_ADR +: 16];
        mem_wdat_q <= sh_q[debug_port_pkg::MEM_DAT +: 8];
      end
      else if (mem_req_q && i_mem_ack)
      begin
        mem_req_q <= 1'b0;
        if (!mem_we_q)
          mem_rdat_q <= i_mem_rdata;
      end
    end
  end

  // RULE20: six comparators, last four software
  for (genvar g = 0; g < NBP; g++)
  begin : g_bp
    always_ff @(posedge i_mclk or negedge i_debug_reset_n)
    begin
      if (!i_debug_reset_n)
      begin
        bp_en_q[g] <= 1'b0;
        bp_adr_q[g] <= '0;
      end
      else if (bp_upd && bp_slot == 3'(g))
      begin
        bp_en_q[g] <= sh_q[debug_port_pkg::BP_EN];
        bp_adr_q[g] <= sh_q[debug_port_pkg::BP_ADR +: PCW];
      end
    end
    assign hit[g] = bp_en_q[g] & i_cpu_fetch & dbg_valid &
                    (bp_adr_q[g] == i_cpu_pc) &
                    ((g < debug_port_pkg::NBP_HW) | sw_active_q);
  end

  wire wb_req = i_wb_cyc & i_wb_stb & ~ack_q;
  wire wb_wr = wb_req & i_wb_we & i_wb_sel[0];
  wire a_mode = i_wb_adr == debug_port_pkg::ADR_MODE;
  wire a_prot = i_wb_adr == debug_port_pkg::ADR_PROT;
  wire a_bit = i_wb_adr == debug_port_pkg::ADR_BITOP;
  wire a_stat = i_wb_adr == debug_port_pkg::ADR_STAT;
  wire key_ok = i_wb_dat[7:0] == debug_port_pkg::PROT_KEY;
  // RULE9: armed key and pin five low
  wire unlock = armed_q & ~lvl[debug_port_pkg::S_P5];
  wire [2:0] bidx = i_wb_dat[2:0];
  wire bval = i_wb_dat[3];
  // RULE10: single-bit write form
  wire [1:0] mode_bit = bidx == 3'h0 ? {mode_q[1], bval} :
                        bidx == 3'h1 ? {bval, mode_q[0]} : mode_q;
  wire [31:0] rd = (a_mode | a_bit) ? {30'h0, mode_q} :
                   a_stat ? {24'h0, stat} : 32'h0;

  always_ff @(posedge i_mclk)
  begin
    if (!i_rstn)
    begin
      dck_q <= 1'b0;
      debug_reset_n_q <= 1'b0;
      ddo_q <= 1'b1;
      ddo_en_n_q <= 1'b1;
      cpu_rst_n_q <= 1'b0;
      port_rst_n_q <= 1'b0;
      nmi_q <= 1'b0;
      hold_q <= 1'b0;
      wait_q <= 1'b0;
      armed_q <= 1'b0;
      ack_q <= 1'b0;
      dat_q <= 32'h0;
    end
    else
    begin
      dck_q <= debug_clock;
      debug_reset_n_q <= debug_reset_n;
      ddo_en_n_q <= ~dbg_valid;
      // RULE5: output moves on the fall only while valid, forced high when invalid
      if (!dbg_valid)
        ddo_q <= 1'b1;
      else if (dck_fall)
        // RULE17: high unless shifting
        ddo_q <= (sh_dr | sh_ir) ? tdo_bit : 1'b1;
      // RULE2: debug reset release resets CPU
      cpu_rst_n_q <= ~(debug_reset_n_rise | pin_rst_eff);
      // RULE19: port buffers always follow the pin
      port_rst_n_q <= ~rst_pin;
      nmi_q <= lvl[debug_port_pkg::S_NMI] & ~m_eff[1];
      hold_q <= lvl[debug_port_pkg::S_HLD] & ~m_eff[2];
      wait_q <= lvl[debug_port_pkg::S_WAIT] & ~m_eff[3];
      if (wb_req)
        armed_q <= wb_wr & a_prot & key_ok;
      ack_q <= wb_req;
      if (wb_req)
        dat_q <= rd;
    end
  end

  // RULE14: system reset restores enable
  always_ff @(posedge i_mclk)
  begin
    if (!i_rstn || rst_pin)
      mode_q <= debug_port_pkg::MODE_RST;
    else if (wb_wr && unlock && a_mode)
      mode_q <= i_wb_dat[1:0];
    else if (wb_wr && unlock && a_bit)
      mode_q <= mode_bit;
  end

  assign o_wb_dat = dat_q;
  assign o_wb_ack = ack_q;
  assign o_debug_data_out = ddo_q;
  assign o_debug_data_out_en_n = ddo_en_n_q;
  assign o_cpu_reset_n = cpu_rst_n_q;
  assign o_port_reset_n = port_rst_n_q;
  assign o_cpu_break = break_q;
  assign o_nmi = nmi_q;
  assign o_bus_hold_request = hold_q;
  assign o_wait = wait_q;
  // RULE11: pin function and pull-down
  assign o_debug_pins_sel = mode_q[debug_port_pkg::MODE_EN];
  assign o_pulldown_off = mode_q[debug_port_pkg::MODE_PD];
  assign o_mem_req = mem_req_q;
  assign o_mem_we = mem_we_q;
  assign o_mem_addr = mem_adr_q;
  assign o_mem_wdata = mem_wdat_q;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rstn || !i_debug_reset_n);

  property p_cpu_rst;
    debug_reset_n_rise |=> !o_cpu_reset_n;
  endproperty
  a_cpu_rst: assert property (p_cpu_rst) // RULE2
    else $error("no CPU reset on debug reset release");
  property p_sample;
    adv && sh_dr && is_id |=> sh_q[79] == $past(debug_data_in);
  endproperty
  a_sample: assert property (p_sample) // RULE4
    else $error("data in not sampled on rise");
  property p_ddo;
    dbg_valid && !dck_fall |=> $stable(o_debug_data_out);
  endproperty
  a_ddo: assert property (p_ddo) // RULE5
    else $error("data out moved without a fall");
  property p_adv;
    !dck_rise || !dbg_valid |=> $stable(st);
  endproperty
  a_adv: assert property (p_adv) // RULE12
    else $error("state moved while idle or invalid");
  property p_lock;
    wb_wr && a_mode && !unlock && !rst_pin |=> $stable(mode_q);
  endproperty
  a_lock: assert property (p_lock) // RULE9
    else $error("locked mode register changed");
  property p_idflag;
    upd && is_id && !i_flash_id[debug_port_pkg::ID_EN]
      |=> !sec_ok_q;
  endproperty
  a_idflag: assert property (p_idflag) // RULE16
    else $error("unlocked with enable flag clear");
  property p_brkmask;
    break_q && dbg_valid && rst_pin && !debug_reset_n_rise
      |=> o_cpu_reset_n;
  endproperty
  a_brkmask: assert property (p_brkmask) // RULE18
    else $error("pin reset reached CPU at break");
  property p_port;
    rst_pin |=> !o_port_reset_n;
  endproperty
  a_port: assert property (p_port) // RULE19
    else $error("port reset not driven");
  property p_high;
    dbg_valid && dck_fall && !sh_dr && !sh_ir
      |=> o_debug_data_out ##1 !o_debug_data_out_en_n;
  endproperty
  a_high: assert property (p_high) // RULE17
    else $error("data out not forced high");
  property p_mem;
    mem_upd && !mem_req_q |=> o_mem_req;
  endproperty
  a_mem: assert property (p_mem) // RULE22
    else $error("memory request not raised");
  c_mem: cover property (mem_upd ##[1:20] !mem_req_q);
  c_unlock: cover property (!sec_ok_q ##1 sec_ok_q);
  c_hit: cover property (any_hit && !break_q ##1 break_q);
endmodule

// File: verification/probe_model.sv
/*
  Debug probe model: drives the serial debug pins and reads
  the data out line. Assumes that line has a pull-up when the
  block does not drive it.
*/
`timescale 1ns/10ps
module probe_model (
  input  wire logic i_mclk,
  input  wire logic i_line,
  output logic      o_rst_n,
  output logic      o_clk,
  output logic      o_ms,
  output logic      o_di
);
  // debug reset held low until first pulse
  initial
  begin
    o_rst_n = 1'b0;
    o_clk   = 1'b0;
    o_ms    = 1'b0;
    o_di    = 1'b0;
  end
  // target always powered, no download: pins driven
  task automatic debug_reset_n();
    @(posedge i_mclk);
    o_rst_n <= 1'b0;
    repeat (4) @(posedge i_mclk);
    o_rst_n <= 1'b1;
  endtask
  // 160 ns link clock, 20 mclk per half
  task automatic step(input logic ms, input logic di,
                      output logic dout);
    @(posedge i_mclk);
    o_clk <= 1'b0;
    o_ms  <= ms;
    o_di  <= di;
    repeat (19) @(posedge i_mclk);
    dout = i_line;
    @(posedge i_mclk);
    o_clk <= 1'b1;
    repeat (19) @(posedge i_mclk);
  endtask
  task automatic walk(input logic [4:0] p, input int k);
    logic t;
    for (int i = 0; i < k; i++)
      step(p[i], 1'b0, t);
  endtask
  // state walk, one bit per clock
  task automatic xfer(input logic [3:0] ir, input logic [79:0] dr,
                      input int n, output logic [3:0] ic,
                      output logic [79:0] dc);
    dc = '0;
    walk(5'b00110, 5);
    for (int i = 0; i < 4; i++)
      step(i == 3, ir[i], ic[i]);
    walk(5'b00011, 4);
    for (int i = 0; i < n; i++)
      step(i == n - 1, dr[i], dc[i]);
    walk(5'b00001, 2);
    // Clock stands still; data in toggles off frame
    o_di <= ~o_di;
  endtask
endmodule

// File: verification/testbench.sv
/*
  Bench for debug_port_top: Wishbone tasks, probe model on the
  serial pins, small memory responder.
  Assumes package and design files are compiled first.
*/
`timescale 1ns/10ps
module testbench;
  logic        mclk, rstn, cyc, we, ack, p5, rpin_n, mack;
  logic        debug_reset_n_n, debug_clock, debug_mode_select, debug_data_in, debug_data_out, en_n, cpu_n, sel, pd;
  logic        mreq, mwe, m_w, nmi, nmo, brk, prt;
  logic [3:0]  bsel;
  logic [7:0]  adr, mwd, m_d;
  logic [15:0] maddr, m_a;
  logic [31:0] wdat, rdat;
  logic [79:0] fid;
  int          err_count, tests_run;
  debug_port_top dut (.i_mclk(mclk), .i_rstn(rstn), .i_wb_cyc(cyc),
    .i_wb_stb(cyc), .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat),
    .i_wb_sel(bsel), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_debug_reset_n(debug_reset_n_n), .i_debug_clock(debug_clock),
    .i_debug_mode_select(debug_mode_select), .i_debug_data_in(debug_data_in),
    .o_debug_data_out(debug_data_out), .o_debug_data_out_en_n(en_n),
    .i_shared_pin_five(p5), .i_reset_pin_n(rpin_n), .i_nmi(nmi),
    .i_bus_hold_request(1'b0), .i_wait_req(1'b0),
    .i_wdt2_reset(1'b0), .i_cpu_pc(24'h0), .i_cpu_fetch(1'b0),
    .i_flash_id(fid), .o_cpu_reset_n(cpu_n), .o_port_reset_n(prt),
    .o_cpu_break(brk), .o_nmi(nmo), .o_bus_hold_request(), .o_wait(),
    .o_debug_pins_sel(sel), .o_pulldown_off(pd), .o_mem_req(mreq),
    .o_mem_we(mwe), .o_mem_addr(maddr), .o_mem_wdata(mwd),
    .i_mem_ack(mack), .i_mem_rdata(~m_a[7:0]));
  probe_model probe (.i_mclk(mclk), .i_line(en_n ? 1'b1 : debug_data_out),
    .o_rst_n(debug_reset_n_n), .o_clk(debug_clock), .o_ms(debug_mode_select), .o_di(debug_data_in));
  always #2 mclk = ~mclk;
  always @(posedge mclk)
  begin
    mack <= mreq && !mack;
    if (mreq && !mack)
    begin
      m_a <= maddr;
      m_w <= mwe;
      m_d <= mwd;
    end
  end
  task automatic end_sim();
    $display("Checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [79:0] e, g);
    tests_run++;
    if (g !== e)
    begin
      $display("Error %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, d,
                    output logic [31:0] r);
    int k;
    @(posedge mclk);
    cyc  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= {24'h0, d};
    for (k = 0; k < 50 && ack !== 1'b1; k++)
      @(posedge mclk);
    r = rdat;
    cyc <= 1'b0;
    if (k == 50)
    begin
      err_count++;
      end_sim();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] r;
    wb(1'b0, a, 8'h0, r);
    chk("read", {72'h0, e}, r);
  endtask
  task automatic wk(input logic [7:0] a, d);
    logic [31:0] r;
    wb(1'b1, debug_port_pkg::ADR_PROT, debug_port_pkg::PROT_KEY, r);
    wb(1'b1, a, d, r);
  endtask
  task automatic t_mode();
    logic [31:0] r;
    rd(debug_port_pkg::ADR_MODE, 8'h01);
    wb(1'b1, debug_port_pkg::ADR_MODE, 8'h02, r);
    rd(debug_port_pkg::ADR_MODE, 8'h01);
    p5 <= 1'b1;
    wk(debug_port_pkg::ADR_MODE, 8'h02);
    rd(debug_port_pkg::ADR_MODE, 8'h01);
    p5 <= 1'b0;
    wk(debug_port_pkg::ADR_MODE, 8'h02);
    rd(debug_port_pkg::ADR_MODE, 8'h02);
    chk("pull-down off", 1, pd);
    chk("debug pins", 0, sel);
    rd(8'h40, 8'h00);
    rpin_n <= 1'b0;
    repeat (10) @(posedge mclk);
    rpin_n <= 1'b1;
    repeat (12) @(posedge mclk);
    rd(debug_port_pkg::ADR_MODE, 8'h01);
    bsel <= 4'h2;
    wk(debug_port_pkg::ADR_BITOP, 8'h09);
    rd(debug_port_pkg::ADR_MODE, 8'h01);
    bsel <= 4'h1;
    wk(debug_port_pkg::ADR_BITOP, 8'h09);
    wk(debug_port_pkg::ADR_BITOP, 8'h0a);
    rd(debug_port_pkg::ADR_BITOP, 8'h03);
    chk("debug pins", 1, sel);
  endtask
  task automatic t_link();
    logic [3:0]  ic;
    logic [79:0] dc;
    int          k;
    probe.debug_reset_n();
    for (k = 0; k < 30 && cpu_n !== 1'b0; k++)
      @(posedge mclk);
    chk("cpu reset seen", 1, k < 30);
    repeat (10) @(posedge mclk);
    rd(debug_port_pkg::ADR_STAT, 8'h09);
    chk("data out idle", 2'b01, {en_n, debug_data_out});
    fid <= 80'h5423f1debc9a78563412;
    @(posedge mclk);
    probe.xfer(debug_port_pkg::IR_IDENT, fid, 80, ic, dc);
    chk("ir capture", 4'b0001, ic);
    rd(debug_port_pkg::ADR_STAT, 8'h09);
    fid <= 80'hd423f1debc9a78563412;
    @(posedge mclk);
    probe.xfer(debug_port_pkg::IR_IDENT, ~fid, 80, ic, dc);
    rd(debug_port_pkg::ADR_STAT, 8'h09);
    probe.xfer(debug_port_pkg::IR_IDENT, fid, 80, ic, dc);
    rd(debug_port_pkg::ADR_STAT, 8'h0d);
    probe.xfer(debug_port_pkg::IR_MEM, {16'h0123, 1'b0}, 25, ic, dc);
    chk("mem read addr", 17'h0246, {m_a, m_w});
    probe.xfer(debug_port_pkg::IR_MEM, {8'h3a, 16'h0456, 1'b1}, 25,
               ic, dc);
    chk("mem read data", 8'hdc, dc[24:17]);
    chk("mem write", 25'h7408ad, {m_d, m_a, m_w});
    nmi <= 1'b1;
    probe.xfer(debug_port_pkg::IR_CTRL, 6'h09, 6, ic, dc);
    chk("break", 1, brk);
    chk("nmi masked", 0, nmo);
    rpin_n <= 1'b0;
    repeat (10) @(posedge mclk);
    chk("reset at break", 2'b10, {cpu_n, prt});
    rpin_n <= 1'b1;
    repeat (12) @(posedge mclk);
    probe.xfer(debug_port_pkg::IR_CTRL, 6'h02, 6, ic, dc);
    chk("resumed", 2'b01, {brk, nmo});
    nmi <= 1'b0;
  endtask
  initial
  begin
    mclk      = 1'b0;
    rstn      = 1'b0;
    cyc       = 1'b0;
    we        = 1'b0;
    adr       = 8'h0;
    wdat      = 32'h0;
    p5        = 1'b0;
    rpin_n    = 1'b1;
    fid       = 80'h0;
    mack      = 1'b0;
    nmi       = 1'b0;
    bsel      = 4'h1;
    err_count = 0;
    tests_run = 0;
    repeat (5) @(posedge mclk);
    rstn <= 1'b1;
    repeat (10) @(posedge mclk);
    t_link();
    t_mode();
    end_sim();
  end
endmodule
